// >>> rtl/dmst_top.sv
// demodulator acquisition, trigger and stream control behind apb
// Functional notes
// R1: a channel streams only while enable is 1; 0 stops all acquisition. The aux output keeps running while enable is 0.
// R2: trigger mode 3 starts streaming on both edges of the trigger.
// R3: trigger mode 1 uses rising edges, mode 2 falling edges.
// R4: source codes 0..3 pick a hardware trigger, 1024 the soft trigger.
// R5: acquisition 0 is continuous, 1 is gated by the trigger.
// R6: each accepted trigger streams a burst of burst-length samples.
// R7: a trigger ignored while a burst runs bumps the busy counter.
// R8: a trigger ignored because memory is full bumps the full counter.
// R9: every discarded stream vector bumps the dropped counter.
// R10: rate rounds to nearest supported divider; samples spaced by it.
// R11: the stream rate never changes the auxiliary sample rate.
// R12: bypass 1 routes samples around the low-pass filter.
// R13: filter order 1..4 selects that many cascaded stages.
// R14: reference frequency is oscillator frequency times harmonic.
// R15: oscillator select 0..7, limited to installed oscillators.
// R16: a programmable phase offset is added to the reference.
// R17: continuous mode ignores triggers; miss counters stay still.
`include "dmst_cfg.svh"
module dmst_top #(
  parameter int N_OSC = 8,
  parameter int MAX_SHIFT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillators and reference
  input wire logic [N_OSC*32-1:0] osc_freq,
  output logic [31:0] ref_phase,
  // raw demodulator samples
  input wire logic smp_valid,
  input wire dmst_pkg::dmst_smp_t smp_x,
  input wire dmst_pkg::dmst_smp_t smp_y,
  // triggers and sample memory
  input wire logic [3:0] hw_trigger,
  input wire logic mem_full,
  // host stream
  output logic st_valid,
  output dmst_pkg::dmst_smp_t st_x,
  output dmst_pkg::dmst_smp_t st_y,
  input wire logic stream_ready,
  // auxiliary path
  output logic aux_valid,
  output dmst_pkg::dmst_smp_t aux_x,
  output dmst_pkg::dmst_smp_t aux_y,
  // interrupt
  output logic irq
);
  import dmst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  dmst_if fif ();
  dmst_filter #(.STAGES(4)) u_filt (.clk(clk), .rstn(rstn), .f(fif));

  // register group
  logic en_q, en_d, byp_q, byp_d, swt_q, swt_d;
  dmst_acq_t acq_q, acq_d;
  dmst_tmode_t mode_q, mode_d;
  logic [2:0] ord_q, ord_d, osc_q, osc_d, wv3;
  logic [10:0] src_q, src_d;
  logic [4:0] sh_q, sh_d;
  logic [31:0] blen_q, blen_d, ph_q, ph_d, prd_q, prd_d, rdat;
  logic [7:0] harm_q, harm_d;
  logic [3:0] imask_q, imask_d, ist_q, ist_d, ev;
  logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d, hit, acc, wr, rd;
  // trigger and burst group
  logic tprev_q, tprev_d, lvl, edge_t, ev_busy, ev_full, ev_start, ev_done;
  dmst_bst_t bs_q, bs_d;
  logic [31:0] left_q, left_d, mb_q, mb_d, mf_q, mf_d;
  // stream group
  logic [31:0] dc_q, dc_d, dlim, drp_q, drp_d;
  logic stv_q, stv_d, gate, emit, blocked, load, ev_drop;
  dmst_smp_t stx_q, stx_d, sty_q, sty_d;
  // reference group
  logic [31:0] acc_q, acc_d, rf_q, rf_d, rp_q, rp_d, osel;

  assign acc = psel && penable && rdy_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  always_comb begin
    rdat = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `DMST_A_CTRL) begin
      rdat[`DMST_F_EN] = en_q;
      rdat[`DMST_F_ACQ] = acq_q;
      rdat[`DMST_F_BYP] = byp_q;
      rdat[`DMST_F_MODE] = mode_q;
      rdat[`DMST_F_ORDER] = ord_q;
      rdat[`DMST_F_OSC] = osc_q;
    end else if (paddr == `DMST_A_TSRC) begin
      rdat[`DMST_F_TSRC] = src_q;
    end else if (paddr == `DMST_A_RATE) begin
      rdat[`DMST_F_SHIFT] = sh_q;
    end else if (paddr == `DMST_A_BLEN) begin
      rdat = blen_q;
    end else if (paddr == `DMST_A_PHASE) begin
      rdat = ph_q;
    end else if (paddr == `DMST_A_HARM) begin
      rdat[`DMST_F_HARM] = harm_q;
    end else if (paddr == `DMST_A_SWTRIG) begin
      rdat = 32'h0000_0000;
    end else if (paddr == `DMST_A_DROP) begin
      rdat = drp_q;
    end else if (paddr == `DMST_A_MBUSY) begin
      rdat = mb_q;
    end else if (paddr == `DMST_A_MFULL) begin
      rdat = mf_q;
    end else if (paddr == `DMST_A_ISTAT) begin
      rdat[`DMST_F_IRQ] = ist_q;
    end else if (paddr == `DMST_A_IMASK) begin
      rdat[`DMST_F_IRQ] = imask_q;
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    en_d = en_q;
    acq_d = acq_q;
    byp_d = byp_q;
    mode_d = mode_q;
    ord_d = ord_q;
    osc_d = osc_q;
    src_d = src_q;
    sh_d = sh_q;
    blen_d = blen_q;
    ph_d = ph_q;
    harm_d = harm_q;
    imask_d = imask_q;
    swt_d = 1'b0;
    wv3 = pwdata[`DMST_F_ORDER];
    // one wait state keeps pready a plain flop
    rdy_d = psel && penable && !rdy_q;
    err_d = psel && penable && !rdy_q && !hit;
    prd_d = (psel && penable && !rdy_q) ? rdat : prd_q;
    if (wr && hit) begin
      if (paddr == `DMST_A_CTRL) begin
        en_d = pwdata[`DMST_F_EN]; // [R1]
        acq_d = dmst_acq_t'(pwdata[`DMST_F_ACQ]); // [R5]
        byp_d = pwdata[`DMST_F_BYP]; // [R12]
        mode_d = dmst_tmode_t'(pwdata[`DMST_F_MODE]);
        // out-of-range order snaps to the nearest legal one
        if (wv3 < `DMST_ORD_MIN) ord_d = `DMST_ORD_MIN; // [R13]
        else if (wv3 > `DMST_ORD_MAX) ord_d = `DMST_ORD_MAX;
        else ord_d = wv3;
        if (pwdata[`DMST_F_OSC] > 3'(N_OSC - 1)) osc_d = 3'(N_OSC - 1); // [R15]
        else osc_d = pwdata[`DMST_F_OSC];
      end else if (paddr == `DMST_A_TSRC) begin
        src_d = pwdata[`DMST_F_TSRC]; // [R4]
      end else if (paddr == `DMST_A_RATE) begin
        // nearest supported divider: power of two, capped
        if (pwdata[`DMST_F_SHIFT] > 5'(MAX_SHIFT)) sh_d = 5'(MAX_SHIFT); // [R10]
        else sh_d = pwdata[`DMST_F_SHIFT];
      end else if (paddr == `DMST_A_BLEN) begin
        blen_d = pwdata; // [R6]
      end else if (paddr == `DMST_A_PHASE) begin
        ph_d = pwdata; // [R16]
      end else if (paddr == `DMST_A_HARM) begin
        harm_d = pwdata[`DMST_F_HARM]; // [R14]
      end else if (paddr == `DMST_A_SWTRIG) begin
        swt_d = pwdata[0];
      end else if (paddr == `DMST_A_IMASK) begin
        imask_d = pwdata[`DMST_F_IRQ];
      end
    end
    ev = 4'h0;
    ev[`DMST_I_DROP] = ev_drop;
    ev[`DMST_I_MBUSY] = ev_busy;
    ev[`DMST_I_MFULL] = ev_full;
    ev[`DMST_I_DONE] = ev_done;
    // a new event in the clearing read's cycle survives the clear
    ist_d = ((rd && paddr == `DMST_A_ISTAT) ? 4'h0 : ist_q) | ev;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_q <= 1'b0;
      acq_q <= ACQ_CONT;
      byp_q <= 1'b0;
      mode_q <= TM_NONE;
      ord_q <= `DMST_RST_ORDER;
      osc_q <= `DMST_RST_OSC;
      src_q <= `DMST_RST_SRC;
      sh_q <= `DMST_RST_SHIFT;
      blen_q <= `DMST_RST_BLEN;
      ph_q <= 32'h0000_0000;
      harm_q <= `DMST_RST_HARM;
      imask_q <= 4'h0;
      ist_q <= 4'h0;
      swt_q <= 1'b0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      prd_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      acq_q <= acq_d;
      byp_q <= byp_d;
      mode_q <= mode_d;
      ord_q <= ord_d;
      osc_q <= osc_d;
      src_q <= src_d;
      sh_q <= sh_d;
      blen_q <= blen_d;
      ph_q <= ph_d;
      harm_q <= harm_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      swt_q <= swt_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      prd_q <= prd_d;
      irq_q <= irq_d;
    end
  end

  // trigger select, edge detect and burst control
  always_comb begin
    lvl = 1'b0;
    if (src_q <= `DMST_SRC_HWMAX) lvl = hw_trigger[src_q[1:0]]; // [R4]
    tprev_d = lvl;
    edge_t = ((mode_q == TM_RISE || mode_q == TM_BOTH) && lvl && !tprev_q)
      || ((mode_q == TM_FALL || mode_q == TM_BOTH) && !lvl && tprev_q)
      || (src_q == `DMST_SRC_SOFT && swt_q); // [R2] [R3] [R4]
    ev_busy = 1'b0;
    ev_full = 1'b0;
    ev_start = 1'b0;
    // continuous mode never looks at triggers
    if (edge_t && acq_q == ACQ_TRIG) begin // [R17]
      if (bs_q == BS_RUN) ev_busy = 1'b1; // [R7]
      else if (mem_full) ev_full = 1'b1; // [R8]
      else if (blen_q != 32'h0000_0000) ev_start = 1'b1;
    end
    mb_d = ev_busy ? mb_q + 32'h0000_0001 : mb_q;
    mf_d = ev_full ? mf_q + 32'h0000_0001 : mf_q;
    ev_done = load && bs_q == BS_RUN && left_q == 32'h0000_0001;
    bs_d = bs_q;
    left_d = left_q;
    case (bs_q)
      BS_IDLE: begin
        if (ev_start) begin
          bs_d = BS_RUN; // [R6]
          left_d = blen_q;
        end
      end
      BS_RUN: begin
        if (acq_q == ACQ_CONT || !en_q) begin
          bs_d = BS_IDLE;
          left_d = 32'h0000_0000;
        end else if (load) begin
          left_d = left_q - 32'h0000_0001;
          if (ev_done) bs_d = BS_IDLE;
        end
      end
      default: bs_d = BS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tprev_q <= 1'b0;
      bs_q <= BS_IDLE;
      left_q <= 32'h0000_0000;
      mb_q <= 32'h0000_0000;
      mf_q <= 32'h0000_0000;
    end else begin
      tprev_q <= tprev_d;
      bs_q <= bs_d;
      left_q <= left_d;
      mb_q <= mb_d;
      mf_q <= mf_d;
    end
  end

  // the filter also feeds aux directly, ahead of the decimator
  assign fif.in_valid = smp_valid;
  assign fif.in_x = smp_x;
  assign fif.in_y = smp_y;
  assign fif.order = ord_q;
  assign fif.bypass = byp_q;

  // decimation and host stream
  always_comb begin
    dlim = (32'h0000_0001 << sh_q) - 32'h0000_0001;
    dc_d = dc_q;
    if (wr && paddr == `DMST_A_RATE) dc_d = 32'h0000_0000;
    else if (fif.out_valid) dc_d = (dc_q >= dlim) ? 32'h0 : dc_q + 32'h1;
    gate = en_q && (acq_q == ACQ_CONT || bs_q == BS_RUN); // [R1] [R5]
    emit = fif.out_valid && dc_q >= dlim && gate; // [R10]
    blocked = stv_q && !stream_ready;
    ev_drop = emit && blocked;
    load = emit && !blocked;
    drp_d = ev_drop ? drp_q + 32'h0000_0001 : drp_q; // [R9]
    stv_d = load ? 1'b1 : (stream_ready ? 1'b0 : stv_q);
    stx_d = load ? fif.out_x : stx_q;
    sty_d = load ? fif.out_y : sty_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dc_q <= 32'h0000_0000;
      drp_q <= 32'h0000_0000;
      stv_q <= 1'b0;
      stx_q <= 16'h0000;
      sty_q <= 16'h0000;
    end else begin
      dc_q <= dc_d;
      drp_q <= drp_d;
      stv_q <= stv_d;
      stx_q <= stx_d;
      sty_q <= sty_d;
    end
  end

  // reference: harmonic times oscillator, plus phase offset
  always_comb begin
    osel = osc_freq[32*osc_q +: 32]; // [R15]
    rf_d = 32'(osel * harm_q); // [R14]
    acc_d = acc_q + rf_q;
    rp_d = acc_q + ph_q; // [R16]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rf_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      rp_q <= 32'h0000_0000;
    end else begin
      rf_q <= rf_d;
      acc_q <= acc_d;
      rp_q <= rp_d;
    end
  end

  assign prdata = prd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign ref_phase = rp_q;
  assign st_valid = stv_q;
  assign st_x = stx_q;
  assign st_y = sty_q;
  assign aux_valid = fif.out_valid; // [R11]
  assign aux_x = fif.out_x;
  assign aux_y = fif.out_y;
  assign irq = irq_q;

  chk_stream_needs_enable: assert property ($rose(stv_q) |-> $past(en_q))
    else $error("stream started while disabled"); // [R1]
  chk_busy_count_step: assert property (ev_busy |=> mb_q == $past(mb_q) + 1)
    else $error("busy miss not counted"); // [R7]
  chk_full_count_step: assert property (ev_full |=> mf_q == $past(mf_q) + 1)
    else $error("full miss not counted"); // [R8]
  chk_drop_count_step: assert property (
    stv_q && !stream_ready && emit |=> drp_q == $past(drp_q) + 1)
    else $error("dropped vector not counted"); // [R9]
  chk_cont_no_miss: assert property (acq_q == ACQ_CONT |=>
    $stable(mb_q) && $stable(mf_q))
    else $error("miss counter moved in continuous mode"); // [R17]
  chk_burst_start_len: assert property (ev_start |=>
    bs_q == BS_RUN && left_q == $past(blen_q))
    else $error("burst not loaded from burst length"); // [R6]
  chk_rising_edge_trig: assert property (
    acq_q == ACQ_TRIG && mode_q == TM_RISE && src_q == 11'h000 &&
    bs_q == BS_IDLE && !mem_full && blen_q != 0 &&
    $rose(hw_trigger[0]) |=> bs_q == BS_RUN)
    else $error("rising edge did not start a burst"); // [R3]
  chk_both_fall_trig: assert property (
    acq_q == ACQ_TRIG && mode_q == TM_BOTH && src_q == 11'h000 &&
    bs_q == BS_IDLE && !mem_full && blen_q != 0 &&
    $fell(hw_trigger[0]) |=> bs_q == BS_RUN)
    else $error("falling edge ignored in both-edge mode"); // [R2]
  chk_rate_capped: assert property (sh_q <= 5'(MAX_SHIFT))
    else $error("rate divider beyond supported range"); // [R10]
  chk_order_legal: assert property (ord_q >= 3'h1 && ord_q <= 3'h4)
    else $error("filter order out of range"); // [R13]
  chk_osc_installed: assert property (32'(osc_q) < N_OSC)
    else $error("oscillator select beyond installed count"); // [R15]
  chk_apb_one_wait: assert property (psel && penable && !rdy_q |=> rdy_q)
    else $error("apb answer late");
endmodule

// >>> common/dmst_cfg.svh
// register map, field positions, reset values and limits of the stream block
`ifndef DMST_CFG_SVH
`define DMST_CFG_SVH
`define DMST_A_CTRL 12'h000
`define DMST_A_TSRC 12'h004
`define DMST_A_RATE 12'h008
`define DMST_A_BLEN 12'h00C
`define DMST_A_PHASE 12'h010
`define DMST_A_HARM 12'h014
`define DMST_A_SWTRIG 12'h018
`define DMST_A_DROP 12'h01C
`define DMST_A_MBUSY 12'h020
`define DMST_A_MFULL 12'h024
`define DMST_A_ISTAT 12'h028
`define DMST_A_IMASK 12'h02C
`define DMST_F_EN 0
`define DMST_F_ACQ 1
`define DMST_F_BYP 2
`define DMST_F_MODE 5:4
`define DMST_F_ORDER 10:8
`define DMST_F_OSC 14:12
`define DMST_F_TSRC 10:0
`define DMST_F_SHIFT 4:0
`define DMST_F_HARM 7:0
`define DMST_F_IRQ 3:0
`define DMST_SRC_SOFT 11'h400
`define DMST_SRC_HWMAX 11'h003
`define DMST_ORD_MIN 3'h1
`define DMST_ORD_MAX 3'h4
`define DMST_RST_ORDER 3'h1
`define DMST_RST_OSC 3'h0
`define DMST_RST_SRC 11'h000
`define DMST_RST_SHIFT 5'h00
`define DMST_RST_BLEN 32'h0000_0001
`define DMST_RST_HARM 8'h01
`define DMST_I_DROP 0
`define DMST_I_MBUSY 1
`define DMST_I_MFULL 2
`define DMST_I_DONE 3
`define DMST_FILT_K 4
`endif

// >>> common/dmst_pkg.sv
// types shared by the stream block
package dmst_pkg;
  typedef logic signed [15:0] dmst_smp_t;
  typedef enum logic [1:0] {
    TM_NONE = 2'b00,
    TM_RISE = 2'b01,
    TM_FALL = 2'b10,
    TM_BOTH = 2'b11
  } dmst_tmode_t;
  typedef enum logic {ACQ_CONT = 1'b0, ACQ_TRIG = 1'b1} dmst_acq_t;
  typedef enum logic {BS_IDLE = 1'b0, BS_RUN = 1'b1} dmst_bst_t;
endpackage

// >>> common/dmst_if.sv
// link between the control block and the low-pass filter chain
interface dmst_if;
  import dmst_pkg::*;
  logic in_valid;
  dmst_smp_t in_x;
  dmst_smp_t in_y;
  logic [2:0] order;
  logic bypass;
  logic out_valid;
  dmst_smp_t out_x;
  dmst_smp_t out_y;
  modport ctl (output in_valid, in_x, in_y, order, bypass,
               input out_valid, out_x, out_y);
  modport flt (input in_valid, in_x, in_y, order, bypass,
               output out_valid, out_x, out_y);
endinterface

// >>> rtl/dmst_filter.sv
// cascaded first-order low-pass stages with order select and bypass
`include "dmst_cfg.svh"
module dmst_filter #(
  parameter int STAGES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // samples and settings
  dmst_if.flt f
);
  import dmst_pkg::*;
  logic v [STAGES+1];
  dmst_smp_t cx [STAGES+1];
  dmst_smp_t cy [STAGES+1];
  logic ov_d, ov_q;
  dmst_smp_t ox_d, oy_d, ox_q, oy_q;
  assign v[0] = f.in_valid;
  assign cx[0] = f.in_x;
  assign cy[0] = f.in_y;
  // stage i runs as a filter only below the order, else it just passes
  for (genvar i = 0; i < STAGES; i++) begin : g_st
    dmst_smp_t sx_d, sy_d, sx_q, sy_q;
    logic v_d, v_q;
    logic signed [16:0] dx, dy;
    always_comb begin
      dx = 17'(cx[i]) - 17'(sx_q);
      dy = 17'(cy[i]) - 17'(sy_q);
      v_d = v[i];
      sx_d = sx_q;
      sy_d = sy_q;
      if (v[i]) begin
        if (3'(i) < f.order) begin // [R13]
          sx_d = sx_q + 16'(dx >>> `DMST_FILT_K);
          sy_d = sy_q + 16'(dy >>> `DMST_FILT_K);
        end else begin
          sx_d = cx[i];
          sy_d = cy[i];
        end
      end
    end
    always_ff @(posedge clk) begin
      if (!rstn) begin
        sx_q <= 16'h0000;
        sy_q <= 16'h0000;
        v_q <= 1'b0;
      end else begin
        sx_q <= sx_d;
        sy_q <= sy_d;
        v_q <= v_d;
      end
    end
    assign v[i+1] = v_q;
    assign cx[i+1] = sx_q;
    assign cy[i+1] = sy_q;
  end
  // bypass skips the whole chain, so it also has less latency
  always_comb begin
    ov_d = f.bypass ? f.in_valid : v[STAGES]; // [R12]
    ox_d = f.bypass ? f.in_x : cx[STAGES];
    oy_d = f.bypass ? f.in_y : cy[STAGES];
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ov_q <= 1'b0;
      ox_q <= 16'h0000;
      oy_q <= 16'h0000;
    end else begin
      ov_q <= ov_d;
      ox_q <= ox_d;
      oy_q <= oy_d;
    end
  end
  assign f.out_valid = ov_q;
  assign f.out_x = ox_q;
  assign f.out_y = oy_q;
  chk_bypass_path: assert property (@(posedge clk) disable iff (!rstn)
    f.bypass && f.in_valid |=> f.out_valid && f.out_x == $past(f.in_x))
    else $error("bypass did not pass the raw sample"); // [R12]
endmodule

// >>> tb/dmst_host.sv
// host side model that takes streamed samples and can stall
module dmst_host
  import dmst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stream from the block
  input wire logic st_valid,
  input wire dmst_smp_t st_x,
  input wire dmst_smp_t st_y,
  output logic stream_ready,
  // bench control and record
  input wire logic stall,
  output int got,
  output dmst_smp_t last_x,
  output dmst_smp_t last_y
);
  timeunit 1ns;
  timeprecision 1ps;
  // a stalled host leaves the sample standing, so later emits must drop
  assign stream_ready = rstn && !stall;
  always @(posedge clk) begin
    if (!rstn) begin
      got <= 0;
    end else if (st_valid === 1'b1 && stream_ready) begin
      got <= got + 1;
      last_x <= st_x;
      last_y <= st_y;
    end
  end
endmodule

// >>> tb/tb_demod_stream_trigger_acquisition.sv
// self-checking bench of the stream, trigger and counter block
`include "dmst_cfg.svh"
module tb_demod_stream_trigger_acquisition;
  import dmst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, ref_phase, r, p0;
  logic pready, pslverr, e, smp_valid = 0, mem_full = 0, stall = 0;
  logic [255:0] osc_freq = 0;
  logic [3:0] hw_trigger = 0;
  dmst_smp_t smp_x = 0, smp_y = 0, st_x, st_y, aux_x, aux_y, aux_last;
  dmst_smp_t last_x, last_y;
  logic st_valid, stream_ready, aux_valid, irq;
  int errors = 0, tests_run = 0, got, aux_cnt = 0, b, a;
  always #5 clk = ~clk;
  dmst_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_freq(osc_freq),
    .ref_phase(ref_phase), .smp_valid(smp_valid), .smp_x(smp_x),
    .smp_y(smp_y), .hw_trigger(hw_trigger), .mem_full(mem_full),
    .st_valid(st_valid), .st_x(st_x), .st_y(st_y),
    .stream_ready(stream_ready), .aux_valid(aux_valid), .aux_x(aux_x),
    .aux_y(aux_y), .irq(irq));
  dmst_host u_host (.clk(clk), .rstn(rstn), .st_valid(st_valid),
    .st_x(st_x), .st_y(st_y), .stream_ready(stream_ready), .stall(stall),
    .got(got), .last_x(last_x), .last_y(last_y));
  always @(posedge clk) begin
    if (aux_valid === 1'b1) begin
      aux_cnt++;
      aux_last = aux_x;
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // request held until pready is seen at an edge, then released
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp,
                    input string msg);
    apb(1'b0, ad, 32'h0000_0000);
    check(r, exp, msg);
  endtask
  task automatic smp(input logic [15:0] x, input int n);
    repeat (n) begin
      smp_valid <= 1;
      smp_x <= x;
      smp_y <= ~x;
      @(posedge clk);
      smp_valid <= 0;
      repeat (9) @(posedge clk);
    end
  endtask
  task automatic trig(input logic v);
    hw_trigger[0] <= v;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic en, acq, byp,
    input logic [1:0] m, input logic [2:0] osc);
    cw = {17'h0, osc, 4'h1, 2'b0, m, 1'b0, byp, acq, en};
  endfunction
  task automatic t_reset();
    rd(`DMST_A_CTRL, 32'h0000_0100, "ctrl reset");
    rd(`DMST_A_BLEN, 32'h0000_0001, "burst reset");
    rd(`DMST_A_HARM, 32'h0000_0001, "harmonic reset");
    rd(12'h030, 32'h0000_0000, "unmapped data");
    check({31'h0, e}, 32'h0000_0001, "unmapped error");
  endtask
  task automatic t_filter();
    wr(`DMST_A_CTRL, cw(1, 0, 0, 2'h0, 3'h0));
    smp(16'h1000, 1);
    check(32'(aux_last), 32'h0000_0100, "one stage output");
    wr(`DMST_A_CTRL, cw(1, 0, 1, 2'h0, 3'h0));
    smp(16'h1234, 1);
    check(32'(last_x), 32'h0000_1234, "bypass stream");
    check(32'(aux_last), 32'h0000_1234, "bypass aux");
  endtask
  task automatic t_disable();
    b = got;
    wr(`DMST_A_CTRL, cw(0, 0, 1, 2'h0, 3'h0));
    smp(16'h0055, 2);
    check(32'(got - b), 32'h0, "disabled stream");
  endtask
  task automatic t_rate();
    wr(`DMST_A_CTRL, cw(1, 0, 1, 2'h0, 3'h0));
    wr(`DMST_A_RATE, 32'h0000_0002);
    b = got;
    a = aux_cnt;
    smp(16'h0101, 8);
    check(32'(got - b), 32'h2, "decimated count");
    check(32'(aux_cnt - a), 32'h8, "aux count");
    wr(`DMST_A_RATE, 32'h0000_0000);
  endtask
  // a stalled host holds one sample, the next two emits are dropped
  task automatic t_drop();
    wr(`DMST_A_IMASK, 32'h0000_0000);
    rd(`DMST_A_ISTAT, 32'h0000_0000, "status clear");
    b = got;
    stall <= 1;
    smp(16'h0202, 3);
    rd(`DMST_A_DROP, 32'h0000_0002, "dropped count");
    check({31'h0, irq}, 32'h0, "masked irq");
    wr(`DMST_A_IMASK, 32'h0000_0001);
    check({31'h0, irq}, 32'h1, "unmasked irq");
    rd(`DMST_A_ISTAT, 32'h0000_0001, "drop status");
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq after clear");
    stall <= 0;
    repeat (3) @(posedge clk);
    check(32'(got - b), 32'h1, "held sample taken");
  endtask
  task automatic t_modes();
    wr(`DMST_A_TSRC, 32'h0000_0000);
    wr(`DMST_A_BLEN, 32'h0000_0003);
    for (int m = 1; m <= 3; m++) begin
      wr(`DMST_A_CTRL, cw(1, 1, 1, 2'(m), 3'h0));
      b = got;
      trig(1);
      smp(16'h0303, 3);
      trig(0);
      smp(16'h0303, 3);
      check(32'(got - b), (m == 3) ? 32'h6 : 32'h3, "burst by mode");
    end
  endtask
  task automatic t_miss();
    wr(`DMST_A_CTRL, cw(1, 1, 1, 2'h1, 3'h0));
    trig(1);
    smp(16'h0404, 1);
    trig(0);
    trig(1);
    smp(16'h0404, 2);
    rd(`DMST_A_MBUSY, 32'h0000_0001, "busy miss");
    trig(0);
    mem_full <= 1;
    trig(1);
    b = got;
    smp(16'h0404, 1);
    check(32'(got - b), 32'h0, "full blocks burst");
    rd(`DMST_A_MFULL, 32'h0000_0001, "full miss");
    mem_full <= 0;
    trig(0);
  endtask
  task automatic t_soft();
    wr(`DMST_A_TSRC, 32'h0000_0400);
    b = got;
    trig(1);
    smp(16'h0505, 1);
    check(32'(got - b), 32'h0, "hw ignored on soft");
    wr(`DMST_A_SWTRIG, 32'h0000_0001);
    smp(16'h0505, 4);
    check(32'(got - b), 32'h3, "soft burst");
    trig(0);
  endtask
  task automatic t_cont();
    wr(`DMST_A_CTRL, cw(1, 0, 1, 2'h3, 3'h0));
    wr(`DMST_A_TSRC, 32'h0000_0000);
    mem_full <= 1;
    trig(1);
    trig(0);
    mem_full <= 0;
    b = got;
    smp(16'h0606, 2);
    trig(1);
    trig(0);
    check(32'(got - b), 32'h2, "continuous stream");
    rd(`DMST_A_MBUSY, 32'h0000_0001, "busy still");
    rd(`DMST_A_MFULL, 32'h0000_0001, "full still");
  endtask
  task automatic t_phase();
    wr(`DMST_A_CTRL, cw(0, 0, 1, 2'h0, 3'h0));
    wr(`DMST_A_PHASE, 32'h4000_0000);
    // the offset and the product each pass a register before ref_phase
    repeat (3) @(posedge clk);
    check(ref_phase, 32'h4000_0000, "phase offset");
    osc_freq[31:0] <= 32'h0000_0010;
    wr(`DMST_A_HARM, 32'h0000_0003);
    repeat (3) @(posedge clk);
    p0 = ref_phase;
    @(posedge clk);
    check(ref_phase - p0, 32'h0000_0030, "harmonic step");
    osc_freq[63:32] <= 32'h0000_0100;
    wr(`DMST_A_CTRL, cw(0, 0, 1, 2'h0, 3'h1));
    repeat (3) @(posedge clk);
    p0 = ref_phase;
    @(posedge clk);
    check(ref_phase - p0, 32'h0000_0300, "second oscillator");
  endtask
  // long stalls or a dead handshake end here instead of hanging
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_reset();
    t_filter();
    t_disable();
    t_rate();
    t_drop();
    t_modes();
    t_miss();
    t_soft();
    t_cont();
    t_phase();
    test_done();
  end
endmodule
